// [rtl/pwm_pkg.sv]
// Purpose: Shared constants for the four-channel down-counting PWM controller
// Assumes: Classic Wishbone, 32-bit data, byte address = register index * 4
// Notes:   Registers are one, eight or ten bits wide, upper data bits read as zero
package pwm_pkg;
    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int          CNT_W    = 10;
    localparam int          NUM_CH   = 4;
    localparam int          ADR_W    = 10;
    localparam logic [9:0]  CMP_ZERO = 10'h000;
    localparam logic [9:0]  CMP_ONES = 10'h3ff;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [7:0]  IDX_RUN_LOAD_INVERT_CTRL = 8'hdc;
    localparam logic [7:0]  IDX_BRAKE_CTRL           = 8'hdf;
    localparam logic [7:0]  IDX_BRAKE_FLAG           = 8'hd7;
    localparam logic [7:0]  IDX_PERIOD_BUF           = 8'he0;
    localparam logic [7:0]  IDX_DUTY_BUF0            = 8'he1;
    localparam logic [7:0]  IDX_COUNT                = 8'he5;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int          BIT_RUN       = 7;
    localparam int          BIT_LOAD      = 6;
    localparam int          BIT_UNDERFLOW = 5;
    localparam int          BIT_CLEAR     = 4;
    localparam int          BIT_HALT_SEL  = 7;
    localparam int          BIT_PIN_POL   = 6;
    localparam int          BIT_PIN_EN    = 5;
    localparam int          BIT_BRAKE_EN  = 4;
    localparam int          BIT_PIN_FLAG  = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_CTRL0 = 8'h00;
    localparam logic [7:0]  RST_CTRL1 = 8'h00;
    localparam logic [9:0]  RST_WORD  = 10'h000;
endpackage : pwm_pkg

// [rtl/pwm_ch_if.sv]
// Purpose: Carries one channel's compare, control and level between top and channel
// Assumes: One instance per channel
// Notes:   Level is the channel's registered pin value
interface pwm_ch_if;
    logic [pwm_pkg::CNT_W-1:0] count;
    logic [pwm_pkg::CNT_W-1:0] compare;
    logic                      run;
    logic                      invert;
    logic                      brake;
    logic                      brake_level;
    logic                      level;

    modport ctl (output count, compare, run, invert, brake, brake_level, input level);
    modport ch  (input count, compare, run, invert, brake, brake_level, output level);
endinterface : pwm_ch_if

// [rtl/pwm_channel.sv]
// Purpose: One PWM output: compare, hold while halted, invert, brake override
// Assumes: Count and compare come from the controller's working registers
// Notes:   Output is registered, one cycle behind the counter
module pwm_channel (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    pwm_ch_if.ch      ch
);
    typedef struct packed {
        logic wave;
        logic level;
    } ch_state_t;

    ch_state_t s_q;
    ch_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (ch.run) begin
            // High until the count falls below compare [R21]
            if (ch.compare == pwm_pkg::CMP_ZERO)
                s_d.wave = 1'b1;                                    // [R22]
            else if (ch.compare == pwm_pkg::CMP_ONES)
                s_d.wave = 1'b0;                                    // [R22]
            else
                s_d.wave = (ch.count >= ch.compare);                // [R21]
        end
        // Halted: wave keeps its last value [R12]
        if (ch.brake)
            s_d.level = ch.brake_level;                             // [R16]
        else
            s_d.level = s_d.wave ^ ch.invert;                       // [R1]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            s_q <= '0;
        else if (ce_i)
            s_q <= s_d;
    end

    assign ch.level = s_q.level;
endmodule : pwm_channel

// [rtl/pwm_brake_select.sv]
// Purpose: Decides whether brake is asserted and whether the pin caused it
// Assumes: Brake pin is synchronous to the clock
// Notes:   Purely combinational
module pwm_brake_select (
    input  wire logic brake_enable_i,
    input  wire logic brake_pin_enable_i,
    input  wire logic brake_on_halt_select_i,
    input  wire logic brake_pin_polarity_i,
    input  wire logic brake_input_pin_i,
    input  wire logic counter_run_i,
    output logic      brake_o,
    output logic      pin_brake_o
);
    logic pin_active;

    assign pin_active = (brake_input_pin_i == brake_pin_polarity_i);   // [R15]

    always_comb begin
        brake_o     = 1'b0;
        pin_brake_o = 1'b0;
        if (brake_enable_i) begin                                       // [R14]
            case ({brake_pin_enable_i, brake_on_halt_select_i})
                2'b00:   brake_o = 1'b1;                                // [R17]
                2'b01:   brake_o = !counter_run_i;                      // [R18]
                2'b10: begin
                    brake_o     = pin_active;                           // [R19]
                    pin_brake_o = pin_active;                           // [R19]
                end
                2'b11:   brake_o = 1'b0;                                // [R20]
                default: brake_o = 1'b0;
            endcase
        end
    end
endmodule : pwm_brake_select

// [rtl/pwm_run_load_brake_control.sv]
// Purpose: Four-channel 10-bit down-counting PWM with run, load, clear and brake
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes:   Every access is acknowledged one cycle after the strobe is seen
// ****************************************************************
// Contract
// ****************************************************************
//
// Contract
// [R1] Each channel has an invert bit that flips its output level.
// [R2] Run bit 7 of control 0 starts the counter; zero keeps it idle.
// [R3] Load bit 6 moves the buffered period in at underflow, then clears.
// [R4] Buffered period and compares move to working registers only at underflow.
// [R5] Load without run transfers nothing; later run alone keeps old values.
// [R6] A run-only write before underflow cancels a pending load.
// [R7] Bit 5 flags counter underflow and raises no interrupt.
// [R8] After a transfer, load and underflow flag clear on the next cycle.
// [R9] Writing one to clear bit 4 forces the counter to zero.
// [R10] Software waits for load to clear before changing control registers.
// [R11] Software should set run and load in one write.
// [R12] Clearing run halts the counter; outputs hold their last level.
// [R13] Software stops cleanly by loading fixed compares, then clearing run.
// [R14] Brake enable bit 4 of control 1 at zero never asserts brake.
// [R15] Brake pin polarity bit 6 selects active high or active low.
// [R16] Under brake each output takes its own brake level bit.
// [R17] Enabled with both selectors zero: brake always asserted.
// [R18] Enabled, halt select only: brake while run is zero.
// [R19] Enabled, pin select only: active pin brakes, clears run, sets flag.
// [R20] Enabled with both selectors set: no brake.
// [R21] Counter reloads period at underflow; output high until below compare.
// [R22] Compare zero keeps output high; compare all ones keeps it low.
// [R23] Pin brake flag bit 0 stays set until software clears it.
//
// Decided for this implementation: the Wishbone slave port.
module pwm_run_load_brake_control #(
    parameter int CNT_W  = pwm_pkg::CNT_W,
    parameter int NUM_CH = pwm_pkg::NUM_CH
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      ce_i,
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [pwm_pkg::ADR_W-1:0] adr_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [31:0]               dat_i,
    output logic      [31:0]               dat_o,
    output logic                           ack_o,
    input  wire logic                      brake_input_pin_i,
    output logic      [NUM_CH-1:0]         pwm_o
);
    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (CNT_W != 10 || NUM_CH != 4) begin : g_bad_param
        $error("Counter must be 10 bits and channel count 4");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]                        ctrl0;
        logic [7:0]                        ctrl1;
        logic                              pin_flag;
        logic [CNT_W-1:0]                  period_buf;
        logic [CNT_W-1:0]                  period_work;
        logic [NUM_CH-1:0][CNT_W-1:0]      duty_buf;
        logic [NUM_CH-1:0][CNT_W-1:0]      cmp_work;
        logic [CNT_W-1:0]                  count;
        logic                              xfer;
        logic                              ack;
        logic [31:0]                       rdata;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    logic       brake;
    logic       pin_brake;
    logic       access;
    logic [7:0] idx;

    assign access = cyc_i && stb_i && !s_q.ack;
    assign idx    = adr_i[pwm_pkg::ADR_W-1:2];

    // ****************************************************************
    // Brake decision
    // ****************************************************************
    pwm_brake_select u_brake (
        .brake_enable_i         (s_q.ctrl1[pwm_pkg::BIT_BRAKE_EN]),
        .brake_pin_enable_i     (s_q.ctrl1[pwm_pkg::BIT_PIN_EN]),
        .brake_on_halt_select_i (s_q.ctrl1[pwm_pkg::BIT_HALT_SEL]),
        .brake_pin_polarity_i   (s_q.ctrl1[pwm_pkg::BIT_PIN_POL]),
        .brake_input_pin_i      (brake_input_pin_i),
        .counter_run_i          (s_q.ctrl0[pwm_pkg::BIT_RUN]),
        .brake_o                (brake),
        .pin_brake_o            (pin_brake)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d     = s_q;
        s_d.ack = access;

        // Bus writes first, so hardware events below win over them
        if (access && we_i) begin
            if (sel_i[0]) begin
                case (idx)
                    pwm_pkg::IDX_RUN_LOAD_INVERT_CTRL: begin
                        // Run-only write drops a pending load [R6]
                        s_d.ctrl0 = dat_i[7:0];
                        // Clear is a strobe and never reads back as one
                        s_d.ctrl0[pwm_pkg::BIT_CLEAR] = 1'b0;
                    end
                    pwm_pkg::IDX_BRAKE_CTRL:
                        s_d.ctrl1 = dat_i[7:0];
                    pwm_pkg::IDX_BRAKE_FLAG:
                        s_d.pin_flag = dat_i[pwm_pkg::BIT_PIN_FLAG];        // [R23]
                    pwm_pkg::IDX_PERIOD_BUF:
                        s_d.period_buf[7:0] = dat_i[7:0];
                    default: begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (idx == pwm_pkg::IDX_DUTY_BUF0 + 8'(i))
                                s_d.duty_buf[i][7:0] = dat_i[7:0];
                        end
                    end
                endcase
            end
            if (sel_i[1]) begin
                if (idx == pwm_pkg::IDX_PERIOD_BUF)
                    s_d.period_buf[CNT_W-1:8] = dat_i[CNT_W-1:8];
                for (int i = 0; i < NUM_CH; i++) begin
                    if (idx == pwm_pkg::IDX_DUTY_BUF0 + 8'(i))
                        s_d.duty_buf[i][CNT_W-1:8] = dat_i[CNT_W-1:8];
                end
            end
        end

        // Read data is captured with the strobe, presented with ack
        s_d.rdata = 32'h0000_0000;
        if (access && !we_i) begin
            case (idx)
                pwm_pkg::IDX_RUN_LOAD_INVERT_CTRL: s_d.rdata[7:0] = s_q.ctrl0;
                pwm_pkg::IDX_BRAKE_CTRL:           s_d.rdata[7:0] = s_q.ctrl1;
                pwm_pkg::IDX_BRAKE_FLAG:
                    s_d.rdata[pwm_pkg::BIT_PIN_FLAG] = s_q.pin_flag;
                pwm_pkg::IDX_PERIOD_BUF:           s_d.rdata[CNT_W-1:0] = s_q.period_buf;
                pwm_pkg::IDX_COUNT:                s_d.rdata[CNT_W-1:0] = s_q.count;
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (idx == pwm_pkg::IDX_DUTY_BUF0 + 8'(i))
                            s_d.rdata[CNT_W-1:0] = s_q.duty_buf[i];
                    end
                end
            endcase
        end

        // One-cycle follow-up of a transfer
        s_d.xfer = 1'b0;
        if (s_q.xfer) begin
            s_d.ctrl0[pwm_pkg::BIT_LOAD]      = 1'b0;                      // [R3] [R8]
            s_d.ctrl0[pwm_pkg::BIT_UNDERFLOW] = 1'b0;                      // [R8]
        end

        // Counter runs only with run set; idle means no underflow [R2] [R5] [R12]
        if (s_q.ctrl0[pwm_pkg::BIT_RUN]) begin
            if (s_q.count == '0) begin
                // Flag only, no interrupt line exists [R7]
                s_d.ctrl0[pwm_pkg::BIT_UNDERFLOW] = 1'b1;
                if (s_q.ctrl0[pwm_pkg::BIT_LOAD]) begin
                    // Sole place working values change [R4]
                    s_d.period_work = s_q.period_buf;
                    s_d.cmp_work    = s_q.duty_buf;
                    s_d.count       = s_q.period_buf;                       // [R3]
                    s_d.xfer        = 1'b1;                                 // [R8]
                end else begin
                    s_d.count = s_q.period_work;                            // [R21]
                end
            end else begin
                s_d.count = s_q.count - 1'b1;
            end
        end

        // Counter clear overrides the count step
        if (access && we_i && sel_i[0] && idx == pwm_pkg::IDX_RUN_LOAD_INVERT_CTRL
            && dat_i[pwm_pkg::BIT_CLEAR])
            s_d.count = '0;                                                 // [R9]

        // Pin brake beats a simultaneous software write
        if (pin_brake) begin
            s_d.ctrl0[pwm_pkg::BIT_RUN] = 1'b0;                             // [R19]
            s_d.pin_flag                = 1'b1;                             // [R19] [R23]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q             <= '0;
            s_q.ctrl0       <= pwm_pkg::RST_CTRL0;
            s_q.ctrl1       <= pwm_pkg::RST_CTRL1;
            s_q.period_buf  <= pwm_pkg::RST_WORD;
            s_q.period_work <= pwm_pkg::RST_WORD;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Channels
    // ****************************************************************
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        pwm_ch_if ch_bus ();

        assign ch_bus.count       = s_q.count;
        assign ch_bus.compare     = s_q.cmp_work[c];
        assign ch_bus.run         = s_q.ctrl0[pwm_pkg::BIT_RUN];           // [R12]
        assign ch_bus.invert      = s_q.ctrl0[c];                          // [R1]
        assign ch_bus.brake       = brake;                                 // [R16]
        assign ch_bus.brake_level = s_q.ctrl1[c];                          // [R16]

        pwm_channel u_ch (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .ce_i  (ce_i),
            .ch    (ch_bus.ch)
        );

        assign pwm_o[c] = ch_bus.level;
    end

    assign ack_o = s_q.ack;
    assign dat_o = s_q.rdata;
endmodule : pwm_run_load_brake_control

// [tb/pwm_ctrl_props.sv]
// Purpose: Port-level checks for the PWM run, load and brake controller
// Assumes: Control 1 and the run bit are shadowed from bus writes
// Notes:   Hardware clearing of run is not shadowed, so those checks stay loose
module pwm_ctrl_props #(
    parameter int NUM_CH = pwm_pkg::NUM_CH
) (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      ce_i,
    input wire logic                      cyc_i,
    input wire logic                      stb_i,
    input wire logic                      we_i,
    input wire logic [pwm_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0]                sel_i,
    input wire logic [31:0]               dat_i,
    input wire logic [31:0]               dat_o,
    input wire logic                      ack_o,
    input wire logic                      brake_input_pin_i,
    input wire logic [NUM_CH-1:0]         pwm_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       take;
    logic       wr;
    logic       pin_act;
    logic [7:0] c1_q;
    logic       run_q;
    logic [1:0] hold_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ********
    // Shadow state
    // ********
    assign take    = cyc_i && stb_i && !ack_o && ce_i;
    assign wr      = take && we_i && sel_i[0];
    assign pin_act = c1_q[5:4] == 2'h3 && !c1_q[7] && brake_input_pin_i == c1_q[6];
    // Any write with sel_i[0] set restarts the quiet count, so halted holds are judged only when idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c1_q   <= 8'h00;
            run_q  <= 1'b0;
            hold_q <= 2'h0;
        end else begin
            if (wr && adr_i[9:2] == pwm_pkg::IDX_BRAKE_CTRL) c1_q <= dat_i[7:0];
            if (wr && adr_i[9:2] == pwm_pkg::IDX_RUN_LOAD_INVERT_CTRL) run_q <= dat_i[7];
            if (wr || run_q || c1_q[4]) hold_q <= 2'h0;
            else if (hold_q != 2'h3) hold_q <= hold_q + 2'h1;
        end
    end
    // ********
    // Properties
    // ********
    property p_ack_follow; take |=> ack_o; endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("request not acked");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_ack_cause; ack_o |-> $past(take); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_c1_read;
        take && !we_i && adr_i[9:2] == pwm_pkg::IDX_BRAKE_CTRL |=> dat_o[7:0] == c1_q;
    endproperty
    a_c1_read: assert property (p_c1_read) else $error("brake control readback");
    property p_soft_brake;
        !c1_q[7] && c1_q[5:4] == 2'h1 && $stable(c1_q) |-> pwm_o == c1_q[NUM_CH-1:0];
    endproperty
    a_soft_brake: assert property (p_soft_brake) else $error("soft brake level");
    property p_pin_brake;
        pin_act && $past(pin_act) && $past(pin_act, 2) && $stable(c1_q)
            |-> pwm_o == c1_q[NUM_CH-1:0];
    endproperty
    a_pin_brake: assert property (p_pin_brake) else $error("pin brake level");
    property p_halt_hold; hold_q == 2'h3 |-> $stable(pwm_o); endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("output moved while halted");
endmodule // pwm_ctrl_props

bind pwm_run_load_brake_control pwm_ctrl_props #(.NUM_CH(NUM_CH)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .brake_input_pin_i(brake_input_pin_i), .pwm_o(pwm_o)
);

// [tb/pwm_pin_partner.sv]
// Purpose: Far-side model of the external brake source on the brake pin
// Assumes: Pin is driven push-pull, so it never floats
// Notes:   Level moves just after a rising edge, like a synchronous source
module pwm_pin_partner (
    input  wire logic clk_i,
    input  wire logic level_i,
    output logic      brake_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        brake_pin_o = 1'b1;
        forever @(posedge clk_i) brake_pin_o <= level_i;
    end
endmodule // pwm_pin_partner

// [tb/pwm_run_load_brake_control_tb_top.sv]
// Purpose: Self-checking bench for the PWM run, load and brake controller
// Assumes: Wishbone ack comes one cycle after the request is taken
// Notes:   Period 15 makes a 32-sample window exactly two periods
module pwm_run_load_brake_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0]  idx;
        logic [31:0] wd;
        logic [31:0] exp;
    } row_t;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    logic        cyc        = 1'b0;
    logic        stb        = 1'b0;
    logic        we         = 1'b0;
    logic [9:0]  adr        = 10'h000;
    logic [31:0] wd         = 32'h0000_0000;
    logic        brake_req  = 1'b1;
    logic        ce         = 1'b1;
    logic [3:0]  sel        = 4'hf;
    logic [31:0] rdat;
    logic        ack;
    logic        brake_pin;
    logic [3:0]  pwm;
    logic [31:0] r;
    logic [31:0] r2;
    logic [3:0]  p;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          h2;
    int          bad;
    row_t        rows [8] = '{
        '{8'hdf, 32'h0000_00a5, 32'h0000_00a5}, '{8'hdf, ZERO, ZERO},
        '{8'he0, 32'h0000_03ff, 32'h0000_03ff}, '{8'h00, 32'h0000_0055, ZERO},
        '{8'hd7, 32'h0000_0001, 32'h0000_0001}, '{8'hd7, ZERO, ZERO},
        '{8'hdc, 32'h0000_001f, 32'h0000_000f}, '{8'he5, 32'h0000_0155, ZERO}};

    pwm_run_load_brake_control dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
        .brake_input_pin_i(brake_pin), .pwm_o(pwm));
    pwm_pin_partner pin (.clk_i(clk_i), .level_i(brake_req), .brake_pin_o(brake_pin));

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // No cycle count assumed for the ack; the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'h0};
        wd  <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        bus(1'b0, idx, ZERO, q);
    endtask
    task automatic load_wait;
        do rd(8'hdc, r); while (r[6] !== 1'b0);
        chk(r, 32'h0000_0088);
    endtask
    task automatic window(input int exp_h2);
        h2 = 0;
        bad = 0;
        repeat (32) begin
            @(posedge clk_i);
            h2 += int'(pwm[2]);
            bad += int'(pwm[0] !== 1'b1 || pwm[1] !== 1'b0 || pwm[3] !== 1'b0);
        end
        chk(32'(bad), ZERO);
        chk(32'(h2), 32'(exp_h2));
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ********
    // Sequence
    // ********
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(pwm), ZERO);
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            rd(rows[i].idx, r);
            chk(r, rows[i].exp);
        end
        // Low byte only: upper period bits must survive
        sel <= 4'h1;
        wr(8'he0, ZERO);
        sel <= 4'hf;
        rd(8'he0, r);
        chk(r, 32'h0000_0300);
        wr(8'he0, 32'h0000_000f);
        wr(8'he1, ZERO);
        wr(8'he2, 32'h0000_03ff);
        wr(8'he3, 32'h0000_0008);
        wr(8'he4, ZERO);
        wr(8'hdc, 32'h0000_00c8);
        load_wait();
        window(16);
        rd(8'hdc, r);
        chk(r, 32'h0000_00a8);
        wr(8'hdc, 32'h0000_0008);
        p = pwm;
        repeat (10) @(posedge clk_i);
        chk(32'(pwm), 32'(p));
        wr(8'he3, ZERO);
        wr(8'hdc, 32'h0000_0048);
        wr(8'hdc, 32'h0000_0088);
        window(16);
        wr(8'hdc, 32'h0000_00c8);
        load_wait();
        window(32);
        // Frozen cycles must not count: three enabled steps between the reads
        rd(8'he5, r);
        ce <= 1'b0;
        repeat (8) @(posedge clk_i);
        ce <= 1'b1;
        rd(8'he5, r2);
        chk(r2, (r + 32'h0000_000d) & 32'h0000_000f);
        wr(8'hdc, 32'h0000_0018);
        rd(8'he5, r);
        chk(r, ZERO);
        wr(8'hdf, 32'h0000_001a);
        chk(32'(pwm), 32'h0000_000a);
        wr(8'hdf, 32'h0000_009a);
        chk(32'(pwm), 32'h0000_000a);
        wr(8'hdc, 32'h0000_0088);
        chk(32'(pwm), 32'h0000_0005);
        wr(8'hdf, 32'h0000_000a);
        chk(32'(pwm), 32'h0000_0005);
        wr(8'hdf, 32'h0000_00ba);
        chk(32'(pwm), 32'h0000_0005);
        wr(8'hdf, 32'h0000_003a);
        chk(32'(pwm), 32'h0000_0005);
        brake_req <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(32'(pwm), 32'h0000_000a);
        rd(8'hdc, r);
        chk(32'(r[7]), ZERO);
        rd(8'hd7, r);
        chk(r, 32'h0000_0001);
        brake_req <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(8'hd7, r);
        chk(r, 32'h0000_0001);
        wr(8'hd7, ZERO);
        rd(8'hd7, r);
        chk(r, ZERO);
        wr(8'hdf, 32'h0000_007a);
        chk(32'(pwm), 32'h0000_000a);
        close_out();
    end
endmodule // pwm_run_load_brake_control_tb_top
